// ### core/module_power_reset_sequencer_defines.vh
// Constants and timing counts for the module power and reset sequencer
// What this block does
// R01 - Button low 50 ms to 4 s is event
// R02 - Button held 4 s forces power off
// R03 - Event wakes from off, stops when running
// R04 - No power-up finish while supply good low
// R05 - Carrier keeps supply good high in S0
// R06 - Reset waits up to 25 ms bus idle
// R07 - Internal reset held 5 to 6 ms
// R08 - Carrier reset output driven low for reset
// R09 - Battery manager alert forces power-on on return
// R10 - Battery low causes orderly power-down
// R11 - Two wake inputs: PCIe and general purpose
// R12 - Suspend notice asserted before suspend entry
// R13 - One extra cold reset after total loss
// R14 - ATX standby up: S5, request main rail
// R15 - ATX waits supply good before S0
// R16 - ATX turn-on high in S5, low in S0
// R17 - Single supply powers up on main connect
// R18 - Single supply leaves S5 on event or reconnect
// R19 - Standby only: S3/S4/S5, S0 needs main
// R20 - Button inputs synchronised, short power button pulses ignored
// R21 - Override beats pending transitions, ends soft-off
`ifndef MODULE_POWER_RESET_SEQUENCER_DEFINES_VH
`define MODULE_POWER_RESET_SEQUENCER_DEFINES_VH
// ==========================================
// Timing in their own units
`define CLK_HZ 100000000
`define BTN_MIN_MS 50
`define BTN_OVR_MS 4000
`define SMB_WAIT_MS 25
`define RST_HOLD_MIN_MS 5
`define RST_HOLD_MAX_MS 6
`define SUSP_NOTICE_US 10
// ==========================================
// Derived cycle counts
`define BTN_MIN_CYC ((`CLK_HZ / 1000) * `BTN_MIN_MS)
`define BTN_OVR_CYC ((`CLK_HZ / 1000) * `BTN_OVR_MS)
`define SMB_WAIT_CYC ((`CLK_HZ / 1000) * `SMB_WAIT_MS)
`define RST_HOLD_CYC ((`CLK_HZ / 1000) * `RST_HOLD_MIN_MS)
`define SUSP_NOTICE_CYC ((`CLK_HZ / 1000000) * `SUSP_NOTICE_US)
// ==========================================
// Power state codes
`define ST_G3 3'd0
`define ST_S5 3'd1
`define ST_WAIT_PG 3'd2
`define ST_S0 3'd3
`define ST_NOTICE 3'd4
`define ST_S3 3'd5
`define ST_S4 3'd6
`endif

// ### core/module_power_reset_sequencer.v
// Power button, supply and reset sequencing logic of the module
`timescale 1ns/100ps
`default_nettype none
`include "module_power_reset_sequencer_defines.vh"
// ==========================================
// Overview
// The sequencer lives in the standby domain and owns three jobs:
//   - timing the power button into short events and a long override,
//   - turning a reset button press into a fixed-length internal reset,
//   - walking the power states G3, S5, S3, S4 and S0 in step with the
//     supply and the carrier.
// Every output is a flop so the carrier never sees decode glitches.
// Supply request outputs change on the same edge as the state code, so
// a watcher may treat the state and the rail request as one picture.
// Limitations:
//   - The button counter is 32 bits wide; override counts above that
//     range would need a wider counter.
//   - Bus idle is trusted as given; a stuck-busy bus costs the full wait.
//   - Only one reset can run at a time; presses during a hold are lost.
// Trade-off: the hold length uses the short end of the allowed window so
// a reboot is as quick as the rules allow.
module module_power_reset_sequencer #(
  parameter integer BTN_MIN_CYC = `BTN_MIN_CYC,
  parameter integer BTN_OVR_CYC = `BTN_OVR_CYC,
  parameter integer SMB_WAIT_CYC = `SMB_WAIT_CYC,
  parameter integer RST_HOLD_CYC = `RST_HOLD_CYC,
  parameter integer SUSP_NOTICE_CYC = `SUSP_NOTICE_CYC
) (
  input wire clk,
  input wire sys_rst,
  input wire power_button_n,
  input wire reset_button_n,
  input wire supply_good,
  input wire main_supply_present,
  input wire standby_rail,
  input wire atx_mode,
  input wire battery_manager_alert_n,
  input wire battery_low_n,
  input wire wake_pcie_n,
  input wire wake_gp_n,
  input wire smbus_idle,
  input wire stay_off_after_fail,
  input wire suspend_req,
  input wire [1:0] suspend_kind,
  input wire battery_lost,
  output reg carrier_reset_n,
  output reg internal_reset,
  output reg suspend_notice_n,
  output reg main_power_on_n,
  output reg psu_turn_on_n,
  output reg module_power_en,
  output reg [2:0] power_state
);
  // ==========================================
  // Synchronisers
  reg [1:0] pb_sync_reg;
  reg [1:0] rb_sync_reg;
  // Two flops each; only the second stage is read
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pb_sync_reg <= 2'b11;
      rb_sync_reg <= 2'b11;
    end else begin
      pb_sync_reg <= {pb_sync_reg[0], power_button_n}; // R20
      rb_sync_reg <= {rb_sync_reg[0], reset_button_n}; // R20
    end
  end
  wire pb_n = pb_sync_reg[1];
  wire rb_n = rb_sync_reg[1];
  reg rb_prev_reg;
  reg main_prev_reg;
  reg first_boot_reg;
  reg extra_reset_pend_reg;
  // ==========================================
  // Power button timing
  reg [31:0] pb_cnt_reg;
  reg pb_event_reg;
  reg pb_override_reg;
  reg pb_ovr_done_reg;
  // Event on release inside window; override fires once per press
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pb_cnt_reg <= 32'h0000_0000;
      pb_event_reg <= 1'b0;
      pb_override_reg <= 1'b0;
      pb_ovr_done_reg <= 1'b0;
    end else begin
      pb_event_reg <= 1'b0;
      pb_override_reg <= 1'b0;
      if (!pb_n) begin
        if (pb_cnt_reg < BTN_OVR_CYC)
          pb_cnt_reg <= pb_cnt_reg + 32'h0000_0001;
        if (pb_cnt_reg == BTN_OVR_CYC - 1 && !pb_ovr_done_reg) begin
          pb_override_reg <= 1'b1; // R02
          pb_ovr_done_reg <= 1'b1;
        end
      end else begin
        // Short glitches never reach the minimum count
        if (pb_cnt_reg >= BTN_MIN_CYC && pb_cnt_reg < BTN_OVR_CYC)
          pb_event_reg <= 1'b1; // R01 R20
        pb_cnt_reg <= 32'h0000_0000;
        pb_ovr_done_reg <= 1'b0;
      end
    end
  end
  // ==========================================
  // Reset button: graceful wait then fixed hold
  localparam [1:0] RS_IDLE = 2'd0;
  localparam [1:0] RS_WAIT = 2'd1;
  localparam [1:0] RS_HOLD = 2'd2;
  reg [1:0] rs_state_reg;
  reg [31:0] rs_cnt_reg;
  reg cold_reset_req_reg;
  // Hold counts from assertion only, so a long press cannot stretch it
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rs_state_reg <= RS_IDLE;
      rs_cnt_reg <= 32'h0000_0000;
      rb_prev_reg <= 1'b1;
      internal_reset <= 1'b0;
      carrier_reset_n <= 1'b0;
    end else begin
      rb_prev_reg <= rb_n;
      case (rs_state_reg)
        RS_IDLE: begin
          internal_reset <= 1'b0;
          carrier_reset_n <= (power_state == `ST_S0);
          if (cold_reset_req_reg) begin
            rs_state_reg <= RS_HOLD;
            rs_cnt_reg <= 32'h0000_0000;
            internal_reset <= 1'b1;
            carrier_reset_n <= 1'b0;
          end else if (rb_prev_reg && !rb_n && power_state == `ST_S0) begin
            rs_state_reg <= RS_WAIT; // R06
            rs_cnt_reg <= 32'h0000_0000;
          end
        end
        RS_WAIT: begin
          rs_cnt_reg <= rs_cnt_reg + 32'h0000_0001;
          if (smbus_idle || rs_cnt_reg >= SMB_WAIT_CYC - 1) begin
            rs_state_reg <= RS_HOLD; // R06
            rs_cnt_reg <= 32'h0000_0000;
            internal_reset <= 1'b1;
            carrier_reset_n <= 1'b0; // R08
          end
        end
        RS_HOLD: begin
          rs_cnt_reg <= rs_cnt_reg + 32'h0000_0001;
          if (rs_cnt_reg >= RST_HOLD_CYC - 1) begin
            rs_state_reg <= RS_IDLE; // R07
            internal_reset <= 1'b0;
          end
        end
        default: rs_state_reg <= RS_IDLE;
      endcase
    end
  end
  // ==========================================
  // Power state machine
  reg [31:0] nt_cnt_reg;
  reg [2:0] target_reg;
  wire wake_any = !wake_pcie_n || !wake_gp_n; // R11
  wire pg_ok = atx_mode ? supply_good : (supply_good && main_supply_present);
  wire auto_on = !battery_manager_alert_n || !stay_off_after_fail; // R09
  // ==========================================
  // Decode helpers
  // Requested sleep depth to state code; unknown kinds fall to soft-off
  function [2:0] sleep_target;
    input [1:0] kind;
    begin
      case (kind)
        2'd1: sleep_target = `ST_S3;
        2'd2: sleep_target = `ST_S4;
        default: sleep_target = `ST_S5;
      endcase
    end
  endfunction
  // True when the rail that starts the module from G3 is up
  function rail_up;
    input atx;
    input stby;
    input main;
    begin
      rail_up = atx ? stby : main;
    end
  endfunction
  // ==========================================
  // Power state machine body
  // Rail request outputs move on the same edge as the state code, so a
  // state of WAIT_PG always comes with the main rail requested and a
  // sleep state never does.
  // Override checked first so it beats any pending transition
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      power_state <= `ST_G3;
      nt_cnt_reg <= 32'h0000_0000;
      target_reg <= `ST_S5;
      main_prev_reg <= 1'b0;
      first_boot_reg <= 1'b1;
      extra_reset_pend_reg <= 1'b0;
      cold_reset_req_reg <= 1'b0;
      suspend_notice_n <= 1'b1;
      main_power_on_n <= 1'b1;
      psu_turn_on_n <= 1'b1;
      module_power_en <= 1'b0;
    end else begin
      main_prev_reg <= main_supply_present;
      cold_reset_req_reg <= 1'b0;
      if (battery_lost)
        first_boot_reg <= 1'b1;
      if (pb_override_reg) begin
        power_state <= `ST_S5; // R02 R21
        suspend_notice_n <= 1'b1;
        module_power_en <= 1'b0;
        main_power_on_n <= 1'b1;
        psu_turn_on_n <= 1'b1;
      end else begin
        case (power_state)
          `ST_G3: begin
            if (rail_up(atx_mode, standby_rail, main_supply_present)) begin
              power_state <= `ST_S5; // R14 R17
              if (atx_mode || auto_on) begin
                power_state <= `ST_WAIT_PG;
                // Ask for the main rail together with the state change
                main_power_on_n <= 1'b0; // R14
                psu_turn_on_n <= 1'b0;
              end
            end
          end
          `ST_S5, `ST_S3, `ST_S4: begin
            module_power_en <= 1'b0;
            psu_turn_on_n <= 1'b1; // R16
            main_power_on_n <= 1'b1;
            suspend_notice_n <= 1'b1;
            if (pb_event_reg || (power_state != `ST_S5 && wake_any) ||
                (!atx_mode && main_supply_present && !main_prev_reg)) begin
              power_state <= `ST_WAIT_PG; // R03 R18
              main_power_on_n <= 1'b0; // R14
              psu_turn_on_n <= 1'b0;
            end
          end
          `ST_WAIT_PG: begin
            main_power_on_n <= 1'b0; // R14
            psu_turn_on_n <= 1'b0;
            // Main rail must be good before S0
            if (pg_ok && main_supply_present) begin
              power_state <= `ST_S0; // R04 R15 R19
              module_power_en <= 1'b1;
              if (first_boot_reg) begin
                extra_reset_pend_reg <= 1'b1; // R13
                // A new loss in this very cycle must win over the clear
                first_boot_reg <= battery_lost;
              end
            end
          end
          `ST_S0: begin
            psu_turn_on_n <= 1'b0; // R16
            if (extra_reset_pend_reg) begin
              cold_reset_req_reg <= 1'b1; // R13
              extra_reset_pend_reg <= 1'b0;
            end
            if (!supply_good) begin
              power_state <= `ST_S5; // R05
              module_power_en <= 1'b0;
              psu_turn_on_n <= 1'b1; // R16
              main_power_on_n <= 1'b1;
            end else if (pb_event_reg || !battery_low_n) begin
              target_reg <= `ST_S5; // R03 R10
              power_state <= `ST_NOTICE;
              suspend_notice_n <= 1'b0; // R12
              nt_cnt_reg <= 32'h0000_0000;
            end else if (suspend_req) begin
              target_reg <= sleep_target(suspend_kind);
              power_state <= `ST_NOTICE;
              suspend_notice_n <= 1'b0; // R12
              nt_cnt_reg <= 32'h0000_0000;
            end
          end
          `ST_NOTICE: begin
            suspend_notice_n <= 1'b0; // R12
            nt_cnt_reg <= nt_cnt_reg + 32'h0000_0001;
            // Rails drop on the edge that leaves the notice phase
            if (nt_cnt_reg >= SUSP_NOTICE_CYC - 1) begin
              power_state <= target_reg; // R19
              suspend_notice_n <= 1'b1;
              module_power_en <= 1'b0;
              psu_turn_on_n <= 1'b1; // R16
              main_power_on_n <= 1'b1;
            end
          end
          default: power_state <= `ST_G3;
        endcase
      end
    end
  end
endmodule // module_power_reset_sequencer
`default_nettype wire

// ### bench/seq_asserts.sv
// Port checker for the power and reset sequencer
`timescale 1ns/100ps
`default_nettype none
module seq_asserts #(
  parameter integer BTN_OVR_CYC = 40,
  parameter integer RST_HOLD_CYC = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic power_button_n,
  input wire logic reset_button_n,
  input wire logic supply_good,
  input wire logic main_supply_present,
  input wire logic atx_mode,
  input wire logic internal_reset,
  input wire logic suspend_notice_n,
  input wire logic psu_turn_on_n,
  input wire logic module_power_en,
  input wire logic [2:0] power_state
);
  logic [7:0] hold_cnt_reg;
  logic [7:0] btn_cnt_reg;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ====
  // Counters; the button count saturates so a long press never wraps
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_cnt_reg <= 8'h00;
      btn_cnt_reg <= 8'h00;
    end else begin
      hold_cnt_reg <= internal_reset ? hold_cnt_reg + 8'h01 : 8'h00;
      btn_cnt_reg <= power_button_n ? 8'h00 : btn_cnt_reg + {7'h00, btn_cnt_reg != 8'hff};
    end
  end
  // ====
  // Properties
  AST_NOTICE_LOW: assert property (power_state == 3'h4 |-> !suspend_notice_n)
    else $error("notice output high in notice phase");
  AST_SUSP_ENTRY: assert property ($rose(power_state[2] && power_state[0] ^ power_state[1])
    |-> $past(power_state) == 3'h4) else $error("suspend entered without notice");
  AST_S0_GOOD: assert property ($rose(power_state == 3'h3) |-> supply_good && $past(supply_good))
    else $error("S0 reached without supply good");
  AST_S0_MAIN: assert property ($rose(power_state == 3'h3) |-> $past(main_supply_present))
    else $error("S0 reached without main supply");
  AST_ATX_S0: assert property (atx_mode && power_state == 3'h3 |-> !psu_turn_on_n && module_power_en)
    else $error("supply outputs wrong in S0");
  AST_ATX_S5: assert property (atx_mode && power_state == 3'h1 |-> psu_turn_on_n && !module_power_en)
    else $error("supply outputs wrong in S5");
  AST_RST_HOLD: assert property ($fell(internal_reset) |-> hold_cnt_reg == RST_HOLD_CYC)
    else $error("internal reset length wrong");
  AST_RST_WAIT: assert property ($fell(reset_button_n) && power_state == 3'h3 && !internal_reset
    |-> ##[1:24] internal_reset) else $error("reset not forced in time");
  AST_OVERRIDE: assert property (btn_cnt_reg == BTN_OVR_CYC + 6
    |-> !module_power_en && power_state == 3'h1) else $error("override missing");
  cover property ($rose(power_state == 3'h3));
  cover property ($fell(internal_reset));
  cover property (power_state == 3'h5);
endmodule // seq_asserts
bind module_power_reset_sequencer seq_asserts #(.BTN_OVR_CYC(BTN_OVR_CYC),
  .RST_HOLD_CYC(RST_HOLD_CYC)) chk_i (.clk(clk), .sys_rst(sys_rst),
  .power_button_n(power_button_n), .reset_button_n(reset_button_n), .supply_good(supply_good),
  .main_supply_present(main_supply_present), .atx_mode(atx_mode),
  .internal_reset(internal_reset), .suspend_notice_n(suspend_notice_n),
  .psu_turn_on_n(psu_turn_on_n), .module_power_en(module_power_en), .power_state(power_state));
`default_nettype wire

// ### bench/carrier_supply.sv
// Carrier supply model: reports supply good a while after turn-on
`timescale 1ns/100ps
`default_nettype none
module carrier_supply #(
  parameter integer SETTLE_CYC = 20
) (
  input wire logic clk,
  input wire logic psu_turn_on_n,
  output var logic supply_good,
  output var logic main_supply_present
);
  logic [7:0] on_cnt_reg = 8'h00;
  // ====
  // Main rail settles slowly; good drops at once when the request goes
  initial supply_good = 1'h0;
  assign main_supply_present = 1'h1;
  always @(posedge clk) begin
    on_cnt_reg <= psu_turn_on_n ? 8'h00 : on_cnt_reg + {7'h00, on_cnt_reg != 8'hff};
    supply_good <= !psu_turn_on_n && on_cnt_reg >= SETTLE_CYC;
  end
endmodule // carrier_supply
`default_nettype wire

// ### bench/tb_top.sv
// Testbench for the power and reset sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic power_button_n = 1'h1, reset_button_n = 1'h1, battery_low_n = 1'h1;
  logic standby_rail = 1'h0, wake_pcie_n = 1'h1, wake_gp_n = 1'h1, suspend_req = 1'h0;
  logic [1:0] suspend_kind = 2'h0;
  logic smbus_idle = 1'h0, battery_lost = 1'h0, battery_manager_alert_n = 1'h1;
  logic supply_good, main_supply_present, carrier_reset_n, internal_reset;
  logic suspend_notice_n, main_power_on_n, psu_turn_on_n, module_power_en;
  logic [2:0] power_state;
  int n_fail = 0;
  int n_tests = 0;
  // ====
  // Design and supply model; test lengths shortened
  module_power_reset_sequencer #(.BTN_MIN_CYC(5), .BTN_OVR_CYC(40), .SMB_WAIT_CYC(10),
    .RST_HOLD_CYC(8), .SUSP_NOTICE_CYC(3)) dut (.clk(clk), .sys_rst(sys_rst),
    .power_button_n(power_button_n), .reset_button_n(reset_button_n),
    .supply_good(supply_good), .main_supply_present(main_supply_present),
    .standby_rail(standby_rail), .atx_mode(1'h1),
    .battery_manager_alert_n(battery_manager_alert_n),
    .battery_low_n(battery_low_n), .wake_pcie_n(wake_pcie_n), .wake_gp_n(wake_gp_n),
    .smbus_idle(smbus_idle), .stay_off_after_fail(1'h0), .suspend_req(suspend_req),
    .suspend_kind(suspend_kind), .battery_lost(battery_lost), .carrier_reset_n(carrier_reset_n),
    .internal_reset(internal_reset), .suspend_notice_n(suspend_notice_n),
    .main_power_on_n(main_power_on_n), .psu_turn_on_n(psu_turn_on_n),
    .module_power_en(module_power_en), .power_state(power_state));
  carrier_supply supply (.clk(clk), .psu_turn_on_n(psu_turn_on_n), .supply_good(supply_good),
    .main_supply_present(main_supply_present));
  initial forever #5 clk = ~clk;
  // ====
  // Compare, bounded wait and button press
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_on(input int w, input logic [7:0] v);
    for (int i = 0; i < 400 && (w ? internal_reset : power_state) !== v; i++) @(negedge clk);
    chk(w ? "internal_reset" : "power_state", v, w ? internal_reset : power_state);
    if ((w ? internal_reset : power_state) !== v) end_of_test();
  endtask
  task automatic press(input int n);
    @(posedge clk) power_button_n <= 1'h0;
    repeat (n) @(posedge clk);
    power_button_n <= 1'h1;
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ====
  // Scenarios
  task automatic t_power_up();
    chk("carrier_reset_n", 8'h00, carrier_reset_n);
    @(posedge clk) standby_rail <= 1'h1;
    wait_on(0, 8'h02);
    chk("main_power_on_n", 8'h00, main_power_on_n);
    wait_on(0, 8'h03);
    @(negedge clk);
    chk("carrier_reset_n", 8'h01, carrier_reset_n);
    wait_on(1, 8'h01);
    wait_on(1, 8'h00);
  endtask
  task automatic t_reset(input logic idle);
    int n = 0;
    @(posedge clk) {reset_button_n, smbus_idle} <= {1'h0, idle};
    wait_on(1, 8'h01);
    for (; internal_reset === 1'h1 && n < 20; n++) @(negedge clk);
    chk("reset_hold", 8'h08, 8'(n));
    @(posedge clk) {reset_button_n, smbus_idle} <= 2'h2;
  endtask
  task automatic t_suspend(input logic [1:0] k, input logic gp);
    @(posedge clk) {suspend_req, suspend_kind} <= {1'h1, k};
    wait_on(0, 8'h04);
    chk("suspend_notice_n", 8'h00, suspend_notice_n);
    @(posedge clk) suspend_req <= 1'h0;
    wait_on(0, k == 2'h1 ? 8'h05 : 8'h06);
    @(posedge clk) {wake_gp_n, wake_pcie_n} <= gp ? 2'h1 : 2'h2;
    wait_on(0, 8'h03);
    @(posedge clk) {wake_gp_n, wake_pcie_n} <= 2'h3;
  endtask
  task automatic t_button();
    press(3);
    repeat (20) @(negedge clk);
    chk("power_state", 8'h03, power_state);
    press(10);
    wait_on(0, 8'h01);
    press(10);
    wait_on(0, 8'h03);
    press(60);
    repeat (10) @(negedge clk);
    chk("module_power_en", 8'h00, module_power_en);
    chk("power_state", 8'h01, power_state);
    @(posedge clk) battery_low_n <= 1'h0;
    press(10);
    wait_on(0, 8'h03);
    wait_on(0, 8'h01);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    t_power_up();
    t_reset(1'h0);
    t_reset(1'h1);
    t_suspend(2'h1, 1'h0);
    t_suspend(2'h2, 1'h1);
    t_button();
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
